// file: design/pin_function_select_bank.sv
// module: apb register bank of pin function selectors and the pin routers it steers
//
// The APB slave port was left to the implementer.
`default_nettype none
module pin_function_select_bank #(
    parameter int GENERAL_PINS = 16
) (
    input  wire logic                      clock,
    input  wire logic                      rstn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [31:0]               paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic [GENERAL_PINS*8-1:0] general_function_lines,
    input  wire logic [GENERAL_PINS-1:0]   general_crossbar_lines,
    input  wire logic [39:0]               flash_function_lines,
    output logic      [GENERAL_PINS-1:0]   general_pin_out,
    output logic      [4:0]                flash_pin_out,
    output logic      [GENERAL_PINS*3-1:0] general_selector,
    output logic      [14:0]               flash_selector
);
    // ****************************************************************
    // elaboration check
    // ****************************************************************
    if (GENERAL_PINS != 2 * pin_select_pkg::group_pins) begin : g_bad_general
        $error("pin_function_select_bank: two groups of eight general pins only");
    end

    // ****************************************************************
    // apb slave
    // ****************************************************************
    pin_select_pkg::apb_state_e state;
    pin_select_pkg::apb_state_e next_state;
    logic [31:0] group1;
    logic [31:0] group2;
    logic [31:0] flash;
    logic [31:0] next_group1;
    logic [31:0] next_group2;
    logic [31:0] next_flash;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic        write_fire;
    logic        hit_group1;
    logic        hit_group2;
    logic        hit_flash;
    logic [31:0] lanes;

    assign hit_group1 = paddr == pin_select_pkg::group1_addr;
    assign hit_group2 = paddr == pin_select_pkg::group2_addr;
    assign hit_flash  = paddr == pin_select_pkg::flash_addr;
    assign write_fire = psel && penable && pready && pwrite;
    assign lanes      = pin_select_pkg::strobe_mask(pstrb);

    // no wait state: the answer is prepared in setup and shown in the first access cycle
    always_comb begin
        next_state   = state;
        next_pready  = 1'b0;
        next_prdata  = prdata;
        next_pslverr = 1'b0;
        case (state)
            pin_select_pkg::apb_idle: begin
                if (psel && !penable) begin
                    next_state   = pin_select_pkg::apb_access;
                    next_pready  = 1'b1;
                    next_pslverr = !(hit_group1 || hit_group2 || hit_flash);
                    if (pwrite) begin
                        next_prdata = 32'h00000000;
                    end else if (hit_group1) begin
                        next_prdata = group1 & pin_select_pkg::group_mask;
                    end else if (hit_group2) begin
                        next_prdata = group2 & pin_select_pkg::group_mask;
                    end else if (hit_flash) begin
                        next_prdata = flash & pin_select_pkg::flash_mask;
                    end else begin
                        next_prdata = 32'h00000000;
                    end
                end
            end
            pin_select_pkg::apb_access: begin
                next_state = pin_select_pkg::apb_idle;
            end
            default: begin
                next_state = pin_select_pkg::apb_idle;
            end
        endcase
    end

    // ****************************************************************
    // selector registers
    // ****************************************************************
    always_comb begin
        logic [31:0] gm;
        logic [31:0] fm;
        gm          = lanes & pin_select_pkg::group_mask;
        fm          = lanes & pin_select_pkg::flash_mask;
        next_group1 = group1;
        next_group2 = group2;
        next_flash  = flash;
        // an erroring write to an unmapped address changes nothing
        if (write_fire && hit_group1) begin
            next_group1 = (group1 & ~gm) | (pwdata & gm);
        end
        if (write_fire && hit_group2) begin
            next_group2 = (group2 & ~gm) | (pwdata & gm);
        end
        if (write_fire && hit_flash) begin
            // flash pins accept any value; correct programming is up to software
            next_flash = (flash & ~fm) | (pwdata & fm);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state   <= pin_select_pkg::apb_idle;
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            group1  <= pin_select_pkg::group1_reset;
            group2  <= pin_select_pkg::group2_reset;
            flash   <= pin_select_pkg::flash_reset;
        end else begin
            state   <= next_state;
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
            group1  <= next_group1;
            group2  <= next_group2;
            flash   <= next_flash;
        end
    end

    // ****************************************************************
    // selector outputs and routers
    // ****************************************************************
    always_comb begin
        for (int i = 0; i < pin_select_pkg::group_pins; i++) begin
            general_selector[i*3 +: 3]      = pin_select_pkg::get_selector(group1, i);
            general_selector[(i+8)*3 +: 3]  = pin_select_pkg::get_selector(group2, i);
        end
        for (int i = 0; i < pin_select_pkg::flash_pins; i++) begin
            flash_selector[i*3 +: 3] = pin_select_pkg::get_selector(flash, i);
        end
    end

    route_if #(.PINS(GENERAL_PINS)) general_route ();
    route_if #(.PINS(pin_select_pkg::flash_pins)) flash_route ();

    assign general_route.selector       = general_selector;
    assign general_route.function_lines = general_function_lines;
    assign general_route.crossbar_lines = general_crossbar_lines;
    assign general_pin_out              = general_route.routed;
    assign flash_route.selector         = flash_selector;
    assign flash_route.function_lines   = flash_function_lines;
    // flash pins have no crossbar: value one is plain function one, the flash clock
    assign flash_route.crossbar_lines   = 5'h00;
    assign flash_pin_out                = flash_route.routed;

    pin_router #(.PINS(GENERAL_PINS), .USE_CROSSBAR(1'b1)) general_router (
        .clock (clock),
        .rstn  (rstn),
        .route (general_route.router)
    );

    pin_router #(.PINS(pin_select_pkg::flash_pins), .USE_CROSSBAR(1'b0)) flash_router (
        .clock (clock),
        .rstn  (rstn),
        .route (flash_route.router)
    );

    // ****************************************************************
    // assertions
    // ****************************************************************
    logic seen_write;
    logic next_seen_write;

    // reset-value checks only hold until software first writes
    always_comb begin
        next_seen_write = seen_write || write_fire;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            seen_write <= 1'b0;
        end else begin
            seen_write <= next_seen_write;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    group1_write_a: assert property (write_fire && hit_group1 && pstrb == 4'hf |=>
        group1 == ($past(pwdata) & pin_select_pkg::group_mask)) else $error("group1 write lost");
    group2_write_a: assert property (write_fire && hit_group2 && pstrb == 4'hf |=>
        group2 == ($past(pwdata) & pin_select_pkg::group_mask)) else $error("group2 write lost");
    flash_write_a: assert property (write_fire && hit_flash && pstrb == 4'hf |=>
        flash == ($past(pwdata) & pin_select_pkg::flash_mask)) else $error("flash write lost");
    reserved_zero_a: assert property ((group1 & ~pin_select_pkg::group_mask) == 0 &&
        (group2 & ~pin_select_pkg::group_mask) == 0 &&
        (flash & ~pin_select_pkg::flash_mask) == 0) else $error("reserved bit set");
    reset_values_a: assert property (!seen_write |->
        group1 == pin_select_pkg::group1_reset && group2 == pin_select_pkg::group2_reset)
        else $error("group reset value wrong");
    flash_reset_a: assert property (!seen_write |-> flash == pin_select_pkg::flash_reset)
        else $error("flash reset value wrong");
    route_crossbar_a: assert property (general_selector[2:0] == 3'h1 |=>
        general_pin_out[0] == $past(general_crossbar_lines[0])) else $error("crossbar route");
    route_function_a: assert property (flash_selector[2:0] == 3'h3 |=>
        flash_pin_out[0] == $past(flash_function_lines[3])) else $error("function route");
    read_answer_a: assert property (psel && !penable && !pwrite && hit_group2 |=>
        pready && prdata == $past(group2)) else $error("read answer wrong");
    unmapped_error_a: assert property (
        psel && !penable && !(hit_group1 || hit_group2 || hit_flash)
        |=> pready && pslverr ##1 !pready) else $error("unmapped answer wrong");

    write_group1_c: cover property (write_fire && hit_group1);
    read_flash_c: cover property (psel && penable && pready && !pwrite && hit_flash);
    crossbar_use_c: cover property (general_selector[5:3] == 3'h1);
    unmapped_c: cover property (pready && pslverr);
endmodule
`default_nettype wire

// file: design/pin_router.sv
// module: per-pin function router with registered pin outputs
`default_nettype none
module pin_router #(
    parameter int PINS         = 8,
    parameter bit USE_CROSSBAR = 1'b1
) (
    input  wire logic clock,
    input  wire logic rstn,
    route_if.router   route
);
    // ****************************************************************
    // elaboration check
    // ****************************************************************
    if (PINS < 1 || PINS > 32) begin : g_bad_pins
        $error("pin_router: PINS out of range");
    end

    logic [PINS-1:0] routed;
    logic [PINS-1:0] next_routed;

    // ****************************************************************
    // routing
    // ****************************************************************
    always_comb begin
        logic [2:0] sel;
        sel = 3'h0;
        for (int i = 0; i < PINS; i++) begin
            sel = route.selector[i*3 +: 3];
            if (USE_CROSSBAR && sel == pin_select_pkg::crossbar_value) begin
                next_routed[i] = route.crossbar_lines[i];
            end else begin
                next_routed[i] = route.function_lines[i*8 + int'(sel)];
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            routed <= '0;
        end else begin
            routed <= next_routed;
        end
    end

    assign route.routed = routed;
endmodule
`default_nettype wire

// file: design/pin_select_pkg.sv
// package: register map, field layout and bus states of the pin function select bank
`default_nettype none
package pin_select_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [31:0] group1_addr  = 32'h4000b048;
    localparam logic [31:0] group2_addr  = 32'h4000b04c;
    localparam logic [31:0] flash_addr   = 32'h4000b068;
    localparam logic [31:0] group1_reset = 32'h00000033;
    localparam logic [31:0] group2_reset = 32'h00000000;
    localparam logic [31:0] flash_reset  = 32'h00000000;
    // ****************************************************************
    // field layout
    // ****************************************************************
    localparam logic [31:0] group_mask     = 32'h77777777;
    localparam logic [31:0] flash_mask     = 32'h00077777;
    localparam int          field_width    = 3;
    localparam int          field_stride   = 4;
    localparam int          group_pins     = 8;
    localparam int          flash_pins     = 5;
    localparam int          function_count = 8;
    localparam logic [2:0]  crossbar_value = 3'h1;

    typedef logic [field_width-1:0] selector_t;

    typedef enum logic [1:0] {
        apb_idle   = 2'b00,
        apb_access = 2'b01
    } apb_state_e;

    function automatic selector_t get_selector(input logic [31:0] word, input int idx);
        get_selector = word[idx*field_stride +: field_width];
    endfunction

    function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
        strobe_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction
endpackage
`default_nettype wire

// file: design/route_if.sv
// interface: selectors and function lines between the register bank and a pin router
`default_nettype none
interface route_if #(
    parameter int PINS = 8
);
    logic [PINS*3-1:0] selector;
    logic [PINS*8-1:0] function_lines;
    logic [PINS-1:0]   crossbar_lines;
    logic [PINS-1:0]   routed;

    modport router (
        input  selector,
        input  function_lines,
        input  crossbar_lines,
        output routed
    );
    modport owner (
        output selector,
        output function_lines,
        output crossbar_lines,
        input  routed
    );
endinterface
`default_nettype wire

// file: verification/testbench.sv
// testbench: apb register and pin routing checks of the pin function select bank
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // signals
    // ****************
    typedef struct {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0]  strb;
        logic [31:0] rdata;
        logic        err;
    } row_s;
    localparam logic [31:0] g1_addr = pin_select_pkg::group1_addr;
    localparam logic [31:0] g2_addr = pin_select_pkg::group2_addr;
    localparam logic [31:0] fl_addr = pin_select_pkg::flash_addr;
    logic         clock;
    logic         rstn;
    logic         psel;
    logic         penable;
    logic         pwrite;
    logic [31:0]  paddr;
    logic [31:0]  pwdata;
    logic [3:0]   pstrb;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic [127:0] gen_lines;
    logic [15:0]  xbar_lines;
    logic [39:0]  fl_lines;
    logic [15:0]  gen_out;
    logic [4:0]   fl_out;
    logic [47:0]  gen_sel;
    logic [14:0]  fl_sel;
    logic [31:0]  rd;
    logic         err;
    logic [3:0]   nib;
    logic [47:0]  exp_g;
    logic [15:0]  exp_go;
    logic [4:0]   exp_fo;
    int           error_cnt;
    int           check_count;
    row_s         rows[6];

    pin_function_select_bank #(.GENERAL_PINS(16)) u_pin_function_select_bank (
        .clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .general_function_lines(gen_lines), .general_crossbar_lines(xbar_lines),
        .flash_function_lines(fl_lines), .general_pin_out(gen_out),
        .flash_pin_out(fl_out), .general_selector(gen_sel), .flash_selector(fl_sel)
    );

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // ****************
    // tasks
    // ****************
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // request stays up after pready; a back-to-back call reassigns psel and drops penable for its own setup
    task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                       input logic [3:0] strb);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        pstrb   <= strb;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            error_cnt++;
            end_of_test();
        end
        rd  = prdata;
        err = pslverr;
    endtask

    task automatic idle(input int cycles);
        psel    <= 1'b0;
        penable <= 1'b0;
        repeat (cycles) @(posedge clock);
    endtask

    task automatic read_reset();
        apb(1'b0, g1_addr, 32'h0, 4'h0);
        check("group1 reset", rd, 32'h00000033);
        apb(1'b0, g2_addr, 32'h0, 4'h0);
        check("group2 reset", rd, 32'h00000000);
        apb(1'b0, fl_addr, 32'h0, 4'h0);
        check("flash reset", rd, 32'h00000000);
        idle(1);
    endtask
    // ****************
    // sequence
    // ****************
    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        gen_lines = {4{32'h5a3c96e1}};
        xbar_lines = 16'ha5c3;
        fl_lines = 40'h69c35a96e1;
        error_cnt = 0;
        check_count = 0;
        rows[0] = '{g1_addr, 32'hffffffff, 4'hf, 32'h77777777, 1'b0};
        rows[1] = '{g2_addr, 32'hffffffff, 4'hf, 32'h77777777, 1'b0};
        rows[2] = '{fl_addr, 32'hffffffff, 4'hf, 32'h00077777, 1'b0};
        rows[3] = '{g1_addr, 32'h00000000, 4'h1, 32'h77777700, 1'b0};
        rows[4] = '{fl_addr, 32'h12345678, 4'h4, 32'h00047777, 1'b0};
        rows[5] = '{32'h4000b050, 32'hffffffff, 4'hf, 32'h00000000, 1'b1};
        repeat (4) @(posedge clock);
        check("group selectors in reset", gen_sel, 48'h1b);
        check("flash selectors in reset", fl_sel, 15'h0);
        rstn <= 1'b1;
        @(posedge clock);
        read_reset();
        $display("test reset values done");
        foreach (rows[i]) begin
            apb(1'b1, rows[i].addr, rows[i].wdata, rows[i].strb);
            check("write response", err, rows[i].err);
            apb(1'b0, rows[i].addr, 32'h0, 4'h0);
            check("read data", rd, rows[i].rdata);
            check("read response", err, rows[i].err);
            idle(1);
        end
        $display("test register rows done");
        apb(1'b1, g1_addr, 32'h76543210, 4'hf);
        apb(1'b1, g2_addr, 32'h01234567, 4'hf);
        apb(1'b1, fl_addr, 32'h00004231, 4'hf);
        idle(2);
        for (int p = 0; p < 8; p++) begin
            exp_g[p*3 +: 3] = p[2:0];
            exp_g[(p+8)*3 +: 3] = 3'h7 - p[2:0];
        end
        check("group selectors", gen_sel, exp_g);
        check("flash selectors", fl_sel, {3'h0, 3'h4, 3'h2, 3'h3, 3'h1});
        $display("test field layout done");
        for (int v = 0; v < 8; v++) begin
            nib = {1'b0, v[2:0]};
            apb(1'b1, g1_addr, {8{nib}}, 4'hf);
            apb(1'b1, g2_addr, {8{nib}}, 4'hf);
            apb(1'b1, fl_addr, {12'h0, {5{nib}}}, 4'hf);
            idle(3);
            for (int p = 0; p < 16; p++) begin
                exp_go[p] = (v == 1) ? xbar_lines[p] : gen_lines[p*8+v];
            end
            for (int q = 0; q < 5; q++) begin
                exp_fo[q] = fl_lines[q*8+v];
            end
            check("general pins", gen_out, exp_go);
            check("flash pins", fl_out, exp_fo);
        end
        $display("test routing done");
        rstn <= 1'b0;
        @(posedge clock);
        check("group selectors in reset", gen_sel, 48'h1b);
        check("flash selectors in reset", fl_sel, 15'h0);
        rstn <= 1'b1;
        @(posedge clock);
        read_reset();
        $display("test second reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
